// File: rtl/periph_off_pkg.sv
// constants and carrier types of the peripheral disable unit
// assumes an 8-bit peripheral side and a 32-bit register bus
package periph_off_pkg;

  // ==========================================================
  // sizes
  localparam int NUM_REGS = 5;
  localparam int NUM_MODS = 40;

  // ==========================================================
  // register byte offsets
  localparam logic [31:0] OFF_SYSCLK_MISC = 32'h0000_0000;
  localparam logic [31:0] OFF_TIMERS      = 32'h0000_0004;
  localparam logic [31:0] OFF_ANALOG      = 32'h0000_0008;
  localparam logic [31:0] OFF_WAVEFORM    = 32'h0000_000c;
  localparam logic [31:0] OFF_SERIAL      = 32'h0000_0010;

  // ==========================================================
  // reset value and implemented bits of each register
  localparam logic [7:0] REG_RESET      = 8'h00; // [RULE_01]
  localparam logic [7:0] MASK_SYSCLK    = 8'hc7; // [RULE_10]
  localparam logic [7:0] MASK_TIMERS    = 8'hff; // [RULE_14]
  localparam logic [7:0] MASK_ANALOG    = 8'h66; // [RULE_15]
  localparam logic [7:0] MASK_WAVEFORM  = 8'hff; // [RULE_16]
  localparam logic [7:0] MASK_SERIAL    = 8'h26; // [RULE_17]
  localparam logic [39:0] IMPL_MASK = {MASK_SERIAL, MASK_WAVEFORM,
    MASK_ANALOG, MASK_TIMERS, MASK_SYSCLK};

  // ==========================================================
  // positions in the flat disable vector (register * 8 + bit)
  localparam int PERIPH_SYSCLK_NET_OFF_POS = 7;  // [RULE_09]
  localparam int VOLTAGE_REF_OFF_POS       = 6;
  localparam int NONVOLATILE_MEM_OFF_POS   = 2;  // [RULE_11]
  localparam int CLOCK_REF_OUT_OFF_POS     = 1;
  localparam int PIN_CHANGE_IRQ_OFF_POS    = 0;  // [RULE_13]
  localparam int TIMER_ZERO_OFF_POS        = 8;
  localparam int NUM_OSC_OFF_POS           = 15;
  localparam int DAC_UNIT_OFF_POS          = 22;
  localparam int ADC_UNIT_OFF_POS          = 21;
  localparam int ASYNC_SERIAL_OFF_POS      = 37;

  // modules fed from the peripheral system clock network
  localparam logic [39:0] SYSCLK_USERS = 40'h26_ff_66_ff_47;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int INSTR_CYCLE_NS = 400;
  // longest wake time, rounded down, never below one cycle
  localparam logic [2:0] WAKE_CYCLES =
    3'((INSTR_CYCLE_NS / CLK_PERIOD_NS < 1) ? 1 :
       INSTR_CYCLE_NS / CLK_PERIOD_NS);

  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic       en;
    logic [2:0] idx;
    logic [7:0] data;
  } reg_wr_t;

  typedef struct packed {
    logic ee_rd;
    logic ee_wr;
    logic ctl_wr;
  } nvm_req_t;

  typedef struct packed {
    logic [39:0] clk_en;
    logic [39:0] rst_hold;
    logic [39:0] analog_off;
    logic [39:0] active;
  } gate_bus_t;

endpackage

// File: rtl/module_gate.sv
// clock, reset and analog gating of one peripheral module
// assumes the disable level comes straight from a register bit
`timescale 1ns/1ns
`default_nettype none
module module_gate (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // control
  input  wire logic off,
  input  wire logic sys_off,
  // to the peripheral
  output logic      clk_en,
  output logic      rst_hold,
  output logic      analog_off,
  output logic      active
);

  typedef struct packed {
    logic       ce;
    logic       rh;
    logic       ao;
    logic       ac;
    logic [2:0] cnt;
  } gate_st_t;

  gate_st_t st_q;
  gate_st_t st_d;

  // ==========================================================
  // next state
  always_comb begin
    st_d    = st_q;
    st_d.ce = !off && !sys_off; // [RULE_02]
    st_d.rh = off; // [RULE_03]
    st_d.ao = off; // [RULE_05]
    if (off) begin
      st_d.cnt = periph_off_pkg::WAKE_CYCLES;
      st_d.ac  = 1'b0;
    end else begin
      // reset released at once, active only after the wake time
      if (st_q.cnt != 3'h0) begin
        st_d.cnt = st_q.cnt - 3'h1; // [RULE_06]
      end
      st_d.ac = (st_q.cnt <= 3'h1); // [RULE_07]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{ce: 1'b1, rh: 1'b0, ao: 1'b0, ac: 1'b1,
                cnt: 3'h0}; // [RULE_01]
    end else begin
      st_q <= st_d; // [RULE_19]
    end
  end

  assign clk_en     = st_q.ce;
  assign rst_hold   = st_q.rh;
  assign analog_off = st_q.ao;
  assign active     = st_q.ac;

endmodule
`default_nettype wire

// File: rtl/access_filter.sv
// blocks cpu register and memory access to disabled modules
// assumes a single shared peripheral register bus from the cpu
`timescale 1ns/1ns
`default_nettype none
module access_filter (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  // disable state
  input  wire logic [39:0]              off_vec,
  // cpu register side
  input  wire logic [5:0]               sfr_sel,
  input  wire logic                     sfr_wr,
  input  wire logic [7:0]               sfr_rdata_in,
  output logic                          periph_sfr_wr,
  output logic [7:0]                    sfr_rdata,
  // data memory side
  input  wire periph_off_pkg::nvm_req_t nvm_req,
  output periph_off_pkg::nvm_req_t      nvm_grant,
  input  wire logic [7:0]               ee_rdata_in,
  output logic [7:0]                    ee_rdata
);

  typedef struct packed {
    logic [7:0] special_function_register;
    logic [7:0] ee;
  } filt_st_t;

  filt_st_t st_q;
  filt_st_t st_d;
  logic     sel_off;
  logic     nvm_off;

  // selects beyond the module range are never blocked
  assign sel_off = (sfr_sel < 6'h28) && off_vec[sfr_sel];
  assign nvm_off = off_vec[periph_off_pkg::NONVOLATILE_MEM_OFF_POS];

  // ==========================================================
  // gating
  always_comb begin
    st_d.special_function_register = sel_off ? 8'h00 : sfr_rdata_in; // [RULE_04]
    st_d.ee  = nvm_off ? 8'h00 : ee_rdata_in; // [RULE_11]
  end

  assign periph_sfr_wr = sfr_wr && !sel_off; // [RULE_04]
  assign nvm_grant = nvm_off ? '0 : nvm_req; // [RULE_11]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata = st_q.special_function_register;
  assign ee_rdata  = st_q.ee;

endmodule
`default_nettype wire

// File: rtl/peripheral_module_disable.sv
// peripheral disable unit: axi4-lite registers and module gating
// assumes all ports synchronous to mclk, one write and one read
// outstanding at most on the register bus
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// [RULE_01] any reset clears every disable bit, all modules run afterwards
// [RULE_02] a disabled module gets no clock or control inputs
// [RULE_03] a disabled module is held in reset while its bit is set
// [RULE_04] writes to a disabled module are dropped, its reads give zero
// [RULE_05] a disabled module has its analog outputs forced off
// [RULE_06] clearing the bit restarts the module from its reset state
// [RULE_07] a re-enabled module may need one instruction cycle to wake
// [RULE_08] software leaves a re-enabled module alone for one instruction
// [RULE_09] bit 7 of register one gates the peripheral system clock net
// [RULE_10] register one: bit 6 voltage ref, bit 1 clock ref out
// [RULE_11] memory disable blocks eeprom access and control writes
// [RULE_12] software waits up to 1 us before using re-enabled memory
// [RULE_13] register one bit 0 disables pin-change logic on all ports
// [RULE_14] register two: oscillator on bit 7, timers six to zero below
// [RULE_15] register three: dac, adc and both comparators
// [RULE_16] register four: waveform generators, pwms, capture units
// [RULE_17] register five: async serial and two sync serial ports
// [RULE_18] unimplemented bits read zero and ignore writes
// [RULE_19] a disable change acts on the clock edge after the write
module peripheral_module_disable (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  // axi4-lite write address
  input  wire logic [31:0]              awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  // axi4-lite write data
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  // axi4-lite write response
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  // axi4-lite read address
  input  wire logic [31:0]              araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  // axi4-lite read data
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  // cpu peripheral register bus
  input  wire logic [5:0]               sfr_sel,
  input  wire logic                     sfr_wr,
  input  wire logic [7:0]               sfr_rdata_in,
  output logic                          periph_sfr_wr,
  output logic [7:0]                    sfr_rdata,
  // data memory access
  input  wire periph_off_pkg::nvm_req_t nvm_req,
  output periph_off_pkg::nvm_req_t      nvm_grant,
  input  wire logic [7:0]               ee_rdata_in,
  output logic [7:0]                    ee_rdata,
  // to the gated modules
  output periph_off_pkg::gate_bus_t     gate_o,
  output logic                          sysclk_net_en,
  output logic                          pin_change_irq_off
);

  typedef struct packed {
    logic                 aw_full;
    logic [31:0]          aw_addr;
    logic                 w_full;
    logic [7:0]           w_data;
    logic                 w_lane;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
    logic [4:0][7:0]      regs;
    logic                 sys_en;
    logic                 ioc_off;
  } top_st_t;

  top_st_t                 st_q;
  top_st_t                 st_d;
  periph_off_pkg::reg_wr_t wr;
  logic [39:0]             off_vec;
  logic                    aw_hit;
  logic                    ar_hit;
  logic [39:0]             ce;
  logic [39:0]             rh;
  logic [39:0]             ao;
  logic [39:0]             ac;

  // ==========================================================
  // address decode
  function automatic logic reg_hit(input logic [31:0] a);
    reg_hit = (a[31:2] < 30'(periph_off_pkg::NUM_REGS)) &&
              (a[1:0] == 2'h0);
  endfunction

  assign aw_hit  = reg_hit(st_q.aw_addr);
  assign ar_hit  = reg_hit(araddr);
  assign off_vec = st_q.regs;

  // address and data held apart until both have arrived
  assign awready = !st_q.aw_full && !st_q.bvalid;
  assign wready  = !st_q.w_full && !st_q.bvalid;
  assign arready = !st_q.rvalid;

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;
    wr   = '0;
    if (awvalid && awready) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      st_d.w_full = 1'b1;
      st_d.w_data = wdata[7:0];
      st_d.w_lane = wstrb[0];
    end
    if (st_q.aw_full && st_q.w_full) begin
      st_d.aw_full = 1'b0;
      st_d.w_full  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = aw_hit ? periph_off_pkg::RESP_OKAY :
                              periph_off_pkg::RESP_SLVERR;
      wr.en   = aw_hit && st_q.w_lane;
      wr.idx  = st_q.aw_addr[4:2];
      wr.data = st_q.w_data;
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = ar_hit ? periph_off_pkg::RESP_OKAY :
                             periph_off_pkg::RESP_SLVERR;
      st_d.rdata  = ar_hit ? st_q.regs[araddr[4:2]] : 8'h00;
    end
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    // masked store keeps unimplemented bits at zero
    if (wr.en) begin
      st_d.regs[wr.idx] = wr.data &
        periph_off_pkg::IMPL_MASK[{wr.idx, 3'h0} +: 8]; // [RULE_18]
    end
    st_d.sys_en  =
      !off_vec[periph_off_pkg::PERIPH_SYSCLK_NET_OFF_POS]; // [RULE_09]
    st_d.ioc_off =
      off_vec[periph_off_pkg::PIN_CHANGE_IRQ_OFF_POS]; // [RULE_13]
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q         <= '0;
      st_q.regs    <= {5{periph_off_pkg::REG_RESET}}; // [RULE_01]
      st_q.sys_en  <= 1'b1;
    end else begin
      st_q <= st_d; // [RULE_19]
    end
  end

  assign bvalid             = st_q.bvalid;
  assign bresp              = st_q.bresp;
  assign rvalid             = st_q.rvalid;
  assign rresp              = st_q.rresp;
  assign rdata              = {24'h0, st_q.rdata};
  assign sysclk_net_en      = st_q.sys_en;
  assign pin_change_irq_off = st_q.ioc_off;

  // ==========================================================
  // per-module gating
  for (genvar i = 0; i < periph_off_pkg::NUM_MODS; i++) begin : g_mod
    if (periph_off_pkg::IMPL_MASK[i] &&
        i != periph_off_pkg::PERIPH_SYSCLK_NET_OFF_POS) begin : g_on
      module_gate u_gate (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .off        (off_vec[i]),
        .sys_off    (periph_off_pkg::SYSCLK_USERS[i] &&
          off_vec[periph_off_pkg::PERIPH_SYSCLK_NET_OFF_POS]),
        .clk_en     (ce[i]),
        .rst_hold   (rh[i]),
        .analog_off (ao[i]),
        .active     (ac[i])
      );
    end else begin : g_none
      // no module behind this position
      assign ce[i] = 1'b1;
      assign rh[i] = 1'b0;
      assign ao[i] = 1'b0;
      assign ac[i] = 1'b1;
    end
  end

  assign gate_o = '{clk_en: ce, rst_hold: rh, analog_off: ao,
                    active: ac};

  // ==========================================================
  // cpu access filtering
  access_filter u_filter (
    .mclk          (mclk),
    .rst_b         (rst_b),
    .off_vec       (off_vec),
    .sfr_sel       (sfr_sel),
    .sfr_wr        (sfr_wr),
    .sfr_rdata_in  (sfr_rdata_in),
    .periph_sfr_wr (periph_sfr_wr),
    .sfr_rdata     (sfr_rdata),
    .nvm_req       (nvm_req),
    .nvm_grant     (nvm_grant),
    .ee_rdata_in   (ee_rdata_in),
    .ee_rdata      (ee_rdata)
  );

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  logic sel_off_c;
  assign sel_off_c = (sfr_sel < 6'h28) && off_vec[sfr_sel];
  // bit 7 feeds the clock network and has no gate of its own
  localparam logic [39:0] GATED = 40'hff_ff_ff_ff_7f;

  a_reset_all_on: assert property ( // [RULE_01]
    $rose(rst_b) |-> (st_q.regs == '0) && (gate_o.clk_en == '1))
    else $error("disable bits not clear after reset");

  a_clock_stops: assert property ( // [RULE_02]
    ##1 (($past(off_vec) & GATED & gate_o.clk_en) == 40'h0))
    else $error("disabled module still clocked");

  a_reset_held: assert property ( // [RULE_03]
    ##1 (($past(off_vec) & GATED & ~gate_o.rst_hold) == 40'h0))
    else $error("disabled module not held in reset");

  a_sfr_write_blocked: assert property ( // [RULE_04]
    sfr_wr && sel_off_c |-> !periph_sfr_wr)
    else $error("write reached a disabled module");

  a_sfr_write_pass: assert property ( // [RULE_04]
    sfr_wr && !sel_off_c |-> periph_sfr_wr)
    else $error("write to enabled module dropped");

  a_sfr_read_zero: assert property ( // [RULE_04]
    sel_off_c |=> sfr_rdata == 8'h00)
    else $error("read of disabled module not zero");

  a_analog_forced: assert property ( // [RULE_05]
    ##1 (($past(off_vec) & GATED & ~gate_o.analog_off) == 40'h0))
    else $error("analog output of disabled module on");

  a_analog_released: assert property ( // [RULE_06]
    ##1 ((~$past(off_vec) & (gate_o.rst_hold | gate_o.analog_off))
      == 40'h0))
    else $error("enabled module still held");

  a_clock_runs: assert property ( // [RULE_06]
    !off_vec[periph_off_pkg::PERIPH_SYSCLK_NET_OFF_POS] |=>
      ((~$past(off_vec) & ~gate_o.clk_en) == 40'h0))
    else $error("enabled module not clocked");

  // the wake count starts at the first edge that sees the bit clear
  a_wake_late: assert property ( // [RULE_06]
    $fell(off_vec[periph_off_pkg::TIMER_ZERO_OFF_POS]) |=>
      !gate_o.active[periph_off_pkg::TIMER_ZERO_OFF_POS] &&
      !gate_o.rst_hold[periph_off_pkg::TIMER_ZERO_OFF_POS])
    else $error("woken module active too early");

  a_wake_bound: assert property ( // [RULE_07]
    $fell(off_vec[periph_off_pkg::TIMER_ZERO_OFF_POS]) ##1
      !off_vec[periph_off_pkg::TIMER_ZERO_OFF_POS] [*3] |=>
      gate_o.active[periph_off_pkg::TIMER_ZERO_OFF_POS])
    else $error("woken module not active in time");

  a_sysclk_gate: assert property ( // [RULE_09]
    off_vec[periph_off_pkg::PERIPH_SYSCLK_NET_OFF_POS] |=>
      !sysclk_net_en)
    else $error("system clock net not gated");

  a_sysclk_restored: assert property ( // [RULE_09]
    !off_vec[periph_off_pkg::PERIPH_SYSCLK_NET_OFF_POS] |=>
      sysclk_net_en)
    else $error("system clock net not restored");

  a_sysclk_users: assert property ( // [RULE_09]
    off_vec[periph_off_pkg::PERIPH_SYSCLK_NET_OFF_POS] |=>
      ((gate_o.clk_en & periph_off_pkg::SYSCLK_USERS) == 40'h0))
    else $error("clock network user still clocked");

  a_nvm_blocked: assert property ( // [RULE_11]
    off_vec[periph_off_pkg::NONVOLATILE_MEM_OFF_POS] |->
      (nvm_grant == '0) ##1 (ee_rdata == 8'h00))
    else $error("memory access while disabled");

  a_nvm_passes: assert property ( // [RULE_11]
    !off_vec[periph_off_pkg::NONVOLATILE_MEM_OFF_POS] |->
      nvm_grant == nvm_req)
    else $error("memory access blocked while enabled");

  a_ioc_all_ports: assert property ( // [RULE_13]
    off_vec[periph_off_pkg::PIN_CHANGE_IRQ_OFF_POS] |=>
      pin_change_irq_off)
    else $error("pin change logic not disabled");

  a_ioc_released: assert property ( // [RULE_13]
    !off_vec[periph_off_pkg::PIN_CHANGE_IRQ_OFF_POS] |=>
      !pin_change_irq_off)
    else $error("pin change logic stuck off");

  a_unimpl_zero: assert property ( // [RULE_18]
    (st_q.regs & ~periph_off_pkg::IMPL_MASK) == 40'h0)
    else $error("unimplemented bit set");

  a_write_next_edge: assert property ( // [RULE_19]
    wr.en |=> st_q.regs[$past(wr.idx)] ==
      ($past(wr.data) &
       periph_off_pkg::IMPL_MASK[{$past(wr.idx), 3'h0} +: 8]))
    else $error("register write not applied");

  a_write_resp: assert property ( // [RULE_19]
    st_q.aw_full && st_q.w_full |=> bvalid)
    else $error("write response missing");

  c_disable_write: cover property (wr.en && wr.data != 8'h00);
  c_reenable: cover property (
    $fell(off_vec[periph_off_pkg::TIMER_ZERO_OFF_POS]) ##4
      gate_o.active[periph_off_pkg::TIMER_ZERO_OFF_POS]);
  c_blocked_read: cover property (sel_off_c && !sfr_wr);
  c_sysclk_off: cover property (!sysclk_net_en);
  c_nvm_blocked: cover property (
    nvm_req.ee_rd && off_vec[periph_off_pkg::NONVOLATILE_MEM_OFF_POS]);

endmodule
`default_nettype wire

// File: dv/periph_model.sv
// behavioural gated peripherals, one byte register per module
// assumes cpu write data and select come from the bench
`timescale 1ns/1ns
`default_nettype none
module periph_model #(
  parameter logic [7:0] EE_DATA = 8'h5a
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  // from the disable unit
  input  wire periph_off_pkg::gate_bus_t gate_o,
  input  wire logic                      periph_sfr_wr,
  input  wire periph_off_pkg::nvm_req_t  nvm_grant,
  // cpu side
  input  wire logic [5:0]                sfr_sel,
  input  wire logic [7:0]                cpu_wdata,
  // read data back
  output logic [7:0]                     sfr_rdata_in,
  output logic [7:0]                     ee_rdata_in
);
  logic [7:0] regs_q [40];
  logic [7:0] noise_q;

  // ==========================================================
  // module registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      noise_q <= 8'h00;
      for (int i = 0; i < 40; i++) regs_q[i] <= 8'h00;
    end else begin
      noise_q <= noise_q + 8'h3b;
      for (int i = 0; i < 40; i++) begin
        if (gate_o.rst_hold[i]) regs_q[i] <= 8'h00;
        else if (periph_sfr_wr && sfr_sel == 6'(i) && gate_o.clk_en[i])
          regs_q[i] <= cpu_wdata;
      end
    end
  end

  // idle lines wander, so stale data never passes for a match
  assign sfr_rdata_in = (sfr_sel < 6'h28) ? regs_q[sfr_sel] : noise_q;
  assign ee_rdata_in  = nvm_grant.ee_rd ? EE_DATA : noise_q;
endmodule
`default_nettype wire

// File: dv/test_peripheral_module_disable.sv
// self-checking bench of the peripheral disable unit
// assumes periph_model stands for the gated peripherals
`timescale 1ns/1ns
`default_nettype none
module test_peripheral_module_disable;
  // ==========================================================
  // signals
  localparam logic [1:0]  OKY  = periph_off_pkg::RESP_OKAY;
  localparam logic [1:0]  SERR = periph_off_pkg::RESP_SLVERR;
  localparam int          TZ   = periph_off_pkg::TIMER_ZERO_OFF_POS;
  localparam logic [39:0] HOLD = 40'h26_ff_66_ff_47;
  localparam logic [31:0] OFFS [5] = '{periph_off_pkg::OFF_SYSCLK_MISC,
    periph_off_pkg::OFF_TIMERS, periph_off_pkg::OFF_ANALOG,
    periph_off_pkg::OFF_WAVEFORM, periph_off_pkg::OFF_SERIAL};
  logic                      mclk, rst_b, sfr_wr, periph_sfr_wr;
  logic [31:0]               awaddr, wdata, araddr, rdata;
  logic                      awvalid, awready, wvalid, wready;
  logic                      bvalid, bready, arvalid, arready;
  logic                      rvalid, rready;
  logic                      sysclk_net_en, pin_change_irq_off;
  logic [3:0]                wstrb;
  logic [1:0]                bresp, rresp;
  logic [5:0]                sfr_sel;
  logic [7:0]                sfr_rdata_in, sfr_rdata, cpu_wdata;
  logic [7:0]                ee_rdata_in, ee_rdata;
  periph_off_pkg::nvm_req_t  nvm_req, nvm_grant;
  periph_off_pkg::gate_bus_t gate_o;
  int                        err_total, n_tests, cyc;

  peripheral_module_disable i_dut (.mclk, .rst_b, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sfr_sel, .sfr_wr, .sfr_rdata_in, .periph_sfr_wr, .sfr_rdata,
    .nvm_req, .nvm_grant, .ee_rdata_in, .ee_rdata, .gate_o,
    .sysclk_net_en, .pin_change_irq_off);
  periph_model i_periph (.mclk, .rst_b, .gate_o, .periph_sfr_wr,
    .nvm_grant, .sfr_sel, .cpu_wdata, .sfr_rdata_in, .ee_rdata_in);

  // ==========================================================
  // checking and bus tasks
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // flags are sampled at the falling edge: inputs only move on rising
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        chk("bresp", {38'h0, er}, {38'h0, r});
        return;
      end
    end
    chk("bvalid", 40'h1, 40'h0);
  endtask

  task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        chk("rdata", {8'h0, ed}, {8'h0, d});
        chk("rresp", {38'h0, er}, {38'h0, r});
        return;
      end
    end
    chk("rvalid", 40'h1, 40'h0);
  endtask

  task automatic sfr_acc(input logic [5:0] sel, input logic wr,
      input logic [7:0] wd, input logic ewr, input logic [7:0] erd);
    @(posedge mclk);
    sfr_sel <= sel;
    sfr_wr <= wr;
    cpu_wdata <= wd;
    @(negedge mclk);
    chk("periph_sfr_wr", {39'h0, ewr}, {39'h0, periph_sfr_wr});
    @(posedge mclk);
    sfr_wr <= 1'b0;
    sfr_sel <= 6'h3f;
    @(negedge mclk);
    chk("sfr_rdata", {32'h0, erd}, {32'h0, sfr_rdata});
  endtask

  task automatic nvm_acc(input logic [2:0] eg, input logic [7:0] erd);
    @(posedge mclk);
    nvm_req <= 3'b111;
    @(negedge mclk);
    chk("nvm_grant", {37'h0, eg}, {37'h0, nvm_grant});
    @(posedge mclk);
    nvm_req <= 3'b000;
    @(negedge mclk);
    chk("ee_rdata", {32'h0, erd}, {32'h0, ee_rdata});
  endtask

  // ==========================================================
  // clock, timeout and test sequence
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // a hung handshake must still reach the report
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  initial begin
    {rst_b, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, sfr_sel, sfr_wr, cpu_wdata, nvm_req} = '0;
    {err_total, n_tests} = '0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) axi_rd(OFFS[i], 32'h0, OKY);
    chk("clk_en", {40{1'b1}}, gate_o.clk_en);
    sfr_acc(6'(TZ), 1'b1, 8'h3c, 1'b1, 8'h00);
    sfr_acc(6'(TZ), 1'b0, 8'h00, 1'b0, 8'h3c);
    for (int i = 0; i < 5; i++) axi_wr(OFFS[i], '1, 4'hf, OKY);
    @(negedge mclk);
    chk("rst_hold", HOLD, gate_o.rst_hold);
    chk("analog_off", HOLD, gate_o.analog_off);
    chk("clk_en", ~HOLD, gate_o.clk_en);
    chk("active", ~HOLD, gate_o.active);
    chk("sysclk_net_en", 40'h0, {39'h0, sysclk_net_en});
    chk("pin_change", 40'h1, {39'h0, pin_change_irq_off});
    axi_rd(OFFS[0], 32'h0000_00c7, OKY);
    axi_rd(OFFS[1], 32'h0000_00ff, OKY);
    axi_rd(OFFS[2], 32'h0000_0066, OKY);
    axi_rd(OFFS[3], 32'h0000_00ff, OKY);
    axi_rd(OFFS[4], 32'h0000_0026, OKY);
    axi_wr(OFFS[2], 32'h0, 4'h0, OKY);
    axi_rd(OFFS[2], 32'h0000_0066, OKY);
    axi_wr(32'h0000_0014, 32'h0, 4'hf, SERR);
    axi_rd(32'h0000_0014, 32'h0, SERR);
    axi_rd(32'h0000_0002, 32'h0, SERR);
    sfr_acc(6'(TZ), 1'b1, 8'h77, 1'b0, 8'h00);
    sfr_acc(6'(TZ), 1'b0, 8'h00, 1'b0, 8'h00);
    nvm_acc(3'b000, 8'h00);
    axi_wr(OFFS[1], 32'h0, 4'hf, OKY);
    @(negedge mclk);
    chk("rst_hold_t0", 40'h0, {39'h0, gate_o.rst_hold[TZ]});
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("active_t0", 40'h0, {39'h0, gate_o.active[TZ]});
    @(posedge mclk);
    @(negedge mclk);
    chk("active_t0", 40'h1, {39'h0, gate_o.active[TZ]});
    sfr_acc(6'(TZ), 1'b0, 8'h00, 1'b0, 8'h00);
    axi_wr(OFFS[0], 32'h0, 4'hf, OKY);
    @(negedge mclk);
    chk("sysclk_net_en", 40'h1, {39'h0, sysclk_net_en});
    repeat (10) @(posedge mclk);
    nvm_acc(3'b111, 8'h5a);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    axi_rd(OFFS[2], 32'h0, OKY);
    chk("rst_hold", 40'h0, gate_o.rst_hold);
    tally_and_finish();
  end
endmodule
`default_nettype wire
